// ==== exec_pkg.sv ====
// shared constants and helpers for the word move, product, dispatch, no-op and or unit
package exec_pkg;

  // opcodes
  localparam logic [7:0] OP_OR_WORK     = 8'h42;
  localparam logic [7:0] OP_OR_WPTR     = 8'h43;
  localparam logic [7:0] OP_OR_REG      = 8'h44;
  localparam logic [7:0] OP_OR_PTR      = 8'h45;
  localparam logic [7:0] OP_OR_LIT      = 8'h46;
  localparam logic [7:0] OP_PROD_REG    = 8'h84;
  localparam logic [7:0] OP_PROD_PTR    = 8'h85;
  localparam logic [7:0] OP_PROD_LIT    = 8'h86;
  localparam logic [7:0] OP_WMOVE_PAIR  = 8'hc4;
  localparam logic [7:0] OP_WMOVE_PTR   = 8'hc5;
  localparam logic [7:0] OP_WMOVE_LIT   = 8'hc6;
  localparam logic [7:0] OP_DISPATCH    = 8'h0f;
  localparam logic [7:0] OP_IDLE        = 8'hff;

  // execution time in core clock cycles
  localparam logic [4:0] CYC_NONE       = 5'h00;
  localparam logic [4:0] CYC_OR_WORK    = 5'h04;
  localparam logic [4:0] CYC_OR         = 5'h06;
  localparam logic [4:0] CYC_PROD       = 5'h16;
  localparam logic [4:0] CYC_WMOVE      = 5'h08;
  localparam logic [4:0] CYC_DISPATCH   = 5'h0a;
  localparam logic [4:0] CYC_IDLE       = 5'h04;
  localparam logic [4:0] CNT_STEP       = 5'h01;

  // instruction lengths in bytes
  localparam logic [15:0] LEN_1         = 16'h0001;
  localparam logic [15:0] LEN_2         = 16'h0002;
  localparam logic [15:0] LEN_3         = 16'h0003;
  localparam logic [15:0] LEN_4         = 16'h0004;
  localparam logic [15:0] TP_STEP       = 16'h0002;

  // flag bit positions
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;

  localparam logic [3:0]  WORK_HI       = 4'hc;
  localparam logic [15:0] BYTE_MAX      = 16'h00ff;

  // bus map, byte addresses
  localparam int          ADDR_W        = 12;
  localparam logic [1:0]  RF_REGION     = 2'h1;
  localparam logic [3:0]  PM_REGION     = 4'h2;
  localparam logic [3:0]  CSR_REGION    = 4'h0;
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  INSTR_OFS     = 8'h04;
  localparam logic [7:0]  FLAG_OFS      = 8'h08;
  localparam logic [7:0]  PC_OFS        = 8'h0c;
  localparam logic [7:0]  TPTR_OFS      = 8'h10;
  localparam int          GO_BIT        = 0;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_ILL        = 1;

  // reset values
  localparam logic [31:0] INSTR_RST     = 32'h0000_00ff;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [15:0] PC_RST        = 16'h0000;
  localparam logic [15:0] TP_RST        = 16'h0000;

  function automatic logic [4:0] op_cycles(input logic [7:0] o);
    unique case (o)
      OP_OR_WORK:                               op_cycles = CYC_OR_WORK;
      OP_OR_WPTR, OP_OR_REG, OP_OR_PTR, OP_OR_LIT: op_cycles = CYC_OR;
      OP_PROD_REG, OP_PROD_PTR, OP_PROD_LIT:    op_cycles = CYC_PROD;
      OP_WMOVE_PAIR, OP_WMOVE_PTR, OP_WMOVE_LIT: op_cycles = CYC_WMOVE;
      OP_DISPATCH:                              op_cycles = CYC_DISPATCH;
      OP_IDLE:                                  op_cycles = CYC_IDLE;
      default:                                  op_cycles = CYC_NONE;
    endcase
  endfunction : op_cycles

  function automatic logic [15:0] op_len(input logic [7:0] o);
    unique case (o)
      OP_OR_WORK, OP_OR_WPTR:  op_len = LEN_2;
      OP_WMOVE_LIT:            op_len = LEN_4;
      OP_DISPATCH, OP_IDLE:    op_len = LEN_1;
      default:                 op_len = LEN_3;
    endcase
  endfunction : op_len

  // byte-enable merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) be_merge[8*i +: 8] = wd[8*i +: 8];
    end
  endfunction : be_merge

endpackage : exec_pkg

// ==== alu_if.sv ====
// operand and result carrier between the sequencer and the arithmetic unit
`timescale 1ns/100ps
interface alu_if;
  logic [7:0]  dst_val;
  logic [7:0]  src_val;
  logic        is_mul;
  logic [7:0]  flags_in;
  logic [15:0] result;
  logic [7:0]  flags_out;

  modport core (output dst_val, output src_val, output is_mul, output flags_in,
                input result, input flags_out);
  modport alu  (input dst_val, input src_val, input is_mul, input flags_in,
                output result, output flags_out);
endinterface : alu_if

// ==== exec_alu.sv ====
// unsigned 8x8 product and bitwise or with their flag effects
`timescale 1ns/100ps
module exec_alu (
  alu_if.alu a
);

  logic [15:0] prod;
  logic [7:0]  orv;
  logic [7:0]  f;

  // both results are formed every cycle; the sequencer picks when to commit
  always_comb begin
    prod = {8'h00, a.dst_val} * {8'h00, a.src_val}; // RULE4
    orv  = a.dst_val | a.src_val;                    // RULE10
    f    = a.flags_in;
    if (a.is_mul) begin
      f[exec_pkg::FL_C] = prod > exec_pkg::BYTE_MAX; // RULE6
      f[exec_pkg::FL_Z] = prod == 16'h0000;          // RULE6
      f[exec_pkg::FL_S] = prod[15];                  // RULE6
    end else begin
      f[exec_pkg::FL_Z] = orv == 8'h00;              // RULE11
      f[exec_pkg::FL_S] = orv[7];                    // RULE11
    end
    f[exec_pkg::FL_V] = 1'b0;                        // RULE6 RULE11
    a.result    = a.is_mul ? prod : {8'h00, orv};
    a.flags_out = f;
  end

endmodule : exec_alu

// ==== exec_unit.sv ====
// sequencer, register file and bus slave for the five-instruction execution unit
// Notes on behaviour
// RULE1 - word move copies a 16-bit source into the destination pair, keeping source and flags.
// RULE2 - word move decodes C4 pair and C5 pointer at 3 bytes and C6 literal at 4, all 8 cycles.
// RULE3 - the even source byte goes to the even destination byte and the odd one to the odd one.
// RULE4 - product multiplies the even destination register by the unsigned source into the pair.
// RULE5 - the product's upper byte lands in the even register and the lower byte in the odd one.
// RULE6 - after a product C is set above 255, Z and S follow it, V clears, D and H hold.
// RULE7 - product is 84 register, 85 pointer, 86 literal source, each 3 bytes and 22 cycles.
// RULE8 - dispatch 0F loads pc from the word at the thread pointer, adds two to it, 10 cycles.
// RULE9 - no-op FF changes nothing and only spends 4 cycles; the code still steps pc by its 1-byte length.
// RULE10 - or writes destination or source into the destination and keeps the source.
// RULE11 - after or zero and sign follow the result, V clears, C, D and H hold.
// RULE12 - or is 42 and 43 at 2 bytes in 4 and 6 cycles, and 44, 45, 46 at 3 bytes in 6 cycles.
// RULE13 - each instruction takes its listed count of core clocks and commits by the last of them.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
module exec_unit (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  typedef enum logic {S_IDLE, S_EXEC} state_t;

  typedef struct packed {
    state_t      state;
    logic [4:0]  cnt;
    logic [31:0] instr;
    logic [7:0]  flags;
    logic [15:0] pc;
    logic [15:0] tp;
    logic        ill;
    logic        rd_done;
    logic [31:0] rdata;
  } st_t;

  localparam st_t ST_RST = '{
    state:   S_IDLE,
    cnt:     exec_pkg::CYC_NONE,
    instr:   exec_pkg::INSTR_RST,
    flags:   exec_pkg::FLAGS_RST,
    pc:      exec_pkg::PC_RST,
    tp:      exec_pkg::TP_RST,
    ill:     1'b0,
    rd_done: 1'b0,
    rdata:   32'h0000_0000
  };

  st_t         st_reg;
  st_t         st_next;

  // register file and program memory
  logic [7:0]  rf_mem [0:255];
  logic [15:0] pm_mem [0:63];

  logic [7:0]  opc;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic [4:0]  cyc;
  logic        is_or;
  logic        is_mul;
  logic        is_wmove;
  logic        is_disp;
  logic        is_idle;
  logic        busy;
  logic        commit;

  logic [7:0]  dst_a;
  logic [7:0]  dp0;
  logic [7:0]  dp1;
  logic [7:0]  sa;
  logic [7:0]  sp1;
  logic        use_lit;
  logic [15:0] lit;
  logic [15:0] src_w;
  logic [7:0]  src_b;
  logic [15:0] wr_w;

  logic        csr_sel;
  logic        rf_sel;
  logic        pm_sel;
  logic [7:0]  ofs;
  logic        stall;
  logic        wr_ok;
  logic        rd_now;
  logic        go;
  logic [31:0] rd_val;

  alu_if       ai ();

  exec_alu u_alu (
    .a (ai.alu)
  );

  // instruction fields and class decode
  assign opc      = st_reg.instr[7:0];
  assign b1       = st_reg.instr[15:8];
  assign b2       = st_reg.instr[23:16];
  assign b3       = st_reg.instr[31:24];
  assign cyc      = exec_pkg::op_cycles(opc); // RULE2 RULE7 RULE12
  assign is_or    = opc inside {exec_pkg::OP_OR_WORK, exec_pkg::OP_OR_WPTR,
                                exec_pkg::OP_OR_REG, exec_pkg::OP_OR_PTR,
                                exec_pkg::OP_OR_LIT};
  assign is_mul   = opc inside {exec_pkg::OP_PROD_REG, exec_pkg::OP_PROD_PTR,
                                exec_pkg::OP_PROD_LIT};
  assign is_wmove = opc inside {exec_pkg::OP_WMOVE_PAIR, exec_pkg::OP_WMOVE_PTR,
                                exec_pkg::OP_WMOVE_LIT};
  assign is_disp  = opc == exec_pkg::OP_DISPATCH;
  assign is_idle  = opc == exec_pkg::OP_IDLE;
  assign busy     = st_reg.state == S_EXEC;
  assign commit   = busy && (st_reg.cnt == exec_pkg::CYC_NONE); // RULE13

  // operand addressing; the register file is frozen while busy, so the
  // operands read here stay stable over the whole execution
  always_comb begin
    dst_a   = 8'h00;
    sa      = 8'h00;
    use_lit = 1'b0;
    lit     = 16'h0000;
    unique case (opc)
      exec_pkg::OP_OR_WORK: begin // RULE12
        dst_a = {exec_pkg::WORK_HI, b1[7:4]};
        sa    = {exec_pkg::WORK_HI, b1[3:0]};
      end
      exec_pkg::OP_OR_WPTR: begin // RULE12
        dst_a = {exec_pkg::WORK_HI, b1[7:4]};
        sa    = rf_mem[{exec_pkg::WORK_HI, b1[3:0]}];
      end
      exec_pkg::OP_OR_REG, exec_pkg::OP_PROD_REG, exec_pkg::OP_WMOVE_PAIR: begin
        dst_a = b2; // RULE2 RULE7 RULE12
        sa    = b1;
      end
      exec_pkg::OP_OR_PTR, exec_pkg::OP_PROD_PTR, exec_pkg::OP_WMOVE_PTR: begin
        dst_a = b2; // RULE2 RULE7 RULE12
        sa    = rf_mem[b1];
      end
      exec_pkg::OP_OR_LIT: begin // RULE12
        dst_a   = b1;
        use_lit = 1'b1;
        lit     = {8'h00, b2};
      end
      exec_pkg::OP_PROD_LIT: begin // RULE7
        dst_a   = b2;
        use_lit = 1'b1;
        lit     = {8'h00, b1};
      end
      exec_pkg::OP_WMOVE_LIT: begin // RULE2
        dst_a   = b1;
        use_lit = 1'b1;
        lit     = {b2, b3};
      end
      default: begin
        dst_a = 8'h00;
      end
    endcase
  end

  // pairs always start on the even register whatever the low address bit says
  assign dp0   = {dst_a[7:1], 1'b0};                       // RULE3 RULE5
  assign dp1   = {dst_a[7:1], 1'b1};                       // RULE3 RULE5
  assign sp1   = {sa[7:1], 1'b1};
  assign src_w = use_lit ? lit : {rf_mem[{sa[7:1], 1'b0}], rf_mem[sp1]}; // RULE3
  assign src_b = use_lit ? lit[7:0] : rf_mem[sa];
  assign wr_w  = is_mul ? ai.result : src_w;              // RULE1 RULE5

  // operands to the arithmetic unit
  assign ai.dst_val  = is_mul ? rf_mem[dp0] : rf_mem[dst_a]; // RULE4
  assign ai.src_val  = src_b;
  assign ai.is_mul   = is_mul;
  assign ai.flags_in = st_reg.flags;

  // bus decode; everything except a status read waits while executing
  assign csr_sel = AVS_ADDRESS[11:8] == exec_pkg::CSR_REGION;
  assign rf_sel  = AVS_ADDRESS[11:10] == exec_pkg::RF_REGION;
  assign pm_sel  = AVS_ADDRESS[11:8] == exec_pkg::PM_REGION;
  assign ofs     = AVS_ADDRESS[7:0];
  assign stall   = busy && !(AVS_READ && csr_sel && ofs == exec_pkg::CTRL_OFS);
  assign wr_ok   = AVS_WRITE && !stall;
  assign rd_now  = AVS_READ && !stall && !st_reg.rd_done;
  assign go      = wr_ok && csr_sel && ofs == exec_pkg::CTRL_OFS && AVS_BYTEENABLE[0]
                   && AVS_WRITEDATA[exec_pkg::GO_BIT];

  // reads take one wait state so read data can come from a flop
  assign AVS_WAITREQUEST = (AVS_WRITE && stall) || (AVS_READ && (stall || !st_reg.rd_done));
  assign AVS_READDATA    = st_reg.rdata;

  // read data selection; unmapped addresses read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rf_sel) begin
      rd_val[7:0] = rf_mem[AVS_ADDRESS[9:2]];
    end else if (pm_sel) begin
      rd_val[15:0] = pm_mem[AVS_ADDRESS[7:2]];
    end else if (csr_sel) begin
      unique case (ofs)
        exec_pkg::CTRL_OFS: begin
          rd_val[exec_pkg::ST_BUSY] = busy;
          rd_val[exec_pkg::ST_ILL]  = st_reg.ill;
        end
        exec_pkg::INSTR_OFS: rd_val = st_reg.instr;
        exec_pkg::FLAG_OFS:  rd_val[7:0] = st_reg.flags;
        exec_pkg::PC_OFS:    rd_val[15:0] = st_reg.pc;
        exec_pkg::TPTR_OFS:  rd_val[15:0] = st_reg.tp;
        default:             rd_val = 32'h0000_0000;
      endcase
    end
  end

  // next state of the sequencer and control registers
  always_comb begin
    logic [31:0] m;
    m       = 32'h0000_0000;
    st_next = st_reg;
    st_next.rd_done = rd_now;
    if (rd_now) st_next.rdata = rd_val;
    if (wr_ok && csr_sel) begin
      unique case (ofs)
        exec_pkg::INSTR_OFS: begin
          st_next.instr = exec_pkg::be_merge(st_reg.instr, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        exec_pkg::FLAG_OFS: begin
          m = exec_pkg::be_merge({24'h0, st_reg.flags}, AVS_WRITEDATA, AVS_BYTEENABLE);
          st_next.flags = m[7:0];
        end
        exec_pkg::PC_OFS: begin
          m = exec_pkg::be_merge({16'h0, st_reg.pc}, AVS_WRITEDATA, AVS_BYTEENABLE);
          st_next.pc = m[15:0];
        end
        exec_pkg::TPTR_OFS: begin
          m = exec_pkg::be_merge({16'h0, st_reg.tp}, AVS_WRITEDATA, AVS_BYTEENABLE);
          st_next.tp = m[15:0];
        end
        default: begin
          m = 32'h0000_0000;
        end
      endcase
    end
    unique case (st_reg.state)
      S_IDLE: begin
        if (go) begin
          // an unknown opcode is refused at once and only raises the flag
          if (cyc != exec_pkg::CYC_NONE) begin
            st_next.state = S_EXEC;
            st_next.cnt   = cyc - exec_pkg::CNT_STEP; // RULE13
            st_next.ill   = 1'b0;
          end else begin
            st_next.ill = 1'b1;
          end
        end
      end
      S_EXEC: begin
        st_next.cnt = st_reg.cnt - exec_pkg::CNT_STEP;
        if (commit) begin
          st_next.state = S_IDLE; // RULE13
          if (is_disp) begin
            st_next.pc = pm_mem[st_reg.tp[6:1]];          // RULE8
            st_next.tp = st_reg.tp + exec_pkg::TP_STEP;   // RULE8
          end else begin
            st_next.pc = st_reg.pc + exec_pkg::op_len(opc); // RULE2 RULE9 RULE12
          end
          // word move, dispatch and no-op leave the flags alone
          if (is_or || is_mul) st_next.flags = ai.flags_out; // RULE6 RULE11
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // memory writes: bus writes only while idle, results only at commit
  always_ff @(posedge CORE_CLK) begin
    if (wr_ok && rf_sel && AVS_BYTEENABLE[0]) rf_mem[AVS_ADDRESS[9:2]] <= AVS_WRITEDATA[7:0];
    if (wr_ok && pm_sel && AVS_BYTEENABLE[0]) pm_mem[AVS_ADDRESS[7:2]][7:0] <= AVS_WRITEDATA[7:0];
    if (wr_ok && pm_sel && AVS_BYTEENABLE[1])
      pm_mem[AVS_ADDRESS[7:2]][15:8] <= AVS_WRITEDATA[15:8];
    if (commit && is_or) rf_mem[dst_a] <= ai.result[7:0]; // RULE10
    if (commit && (is_mul || is_wmove)) begin
      rf_mem[dp0] <= wr_w[15:8]; // RULE1 RULE3 RULE5
      rf_mem[dp1] <= wr_w[7:0];  // RULE1 RULE3 RULE5
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking

  default disable iff (RST);

  idle_len_a: assert property ((go && is_idle) |=> busy [*4] ##1 !busy) // RULE9
    else $error("no-op did not take four cycles");

  wmove_len_a: assert property ((go && is_wmove) |=> busy [*8] ##1 !busy) // RULE2
    else $error("word move did not take eight cycles");

  prod_cnt_a: assert property ((go && is_mul) |=> busy && st_reg.cnt == 5'h15) // RULE7
    else $error("product count not loaded for 22 cycles");

  disp_cnt_a: assert property ((go && is_disp) |=> busy && st_reg.cnt == 5'h09) // RULE8
    else $error("dispatch count not loaded for 10 cycles");

  or_work_a: assert property ((go && opc == exec_pkg::OP_OR_WORK) // RULE12
      |=> st_reg.cnt == 5'h03)
    else $error("or working form count not loaded for 4 cycles");

  disp_tp_a: assert property ((commit && is_disp) // RULE8
      |=> st_reg.tp == $past(st_reg.tp) + 16'h0002)
    else $error("thread pointer not advanced by two");

  wmove_flag_a: assert property ((commit && (is_wmove || is_disp || is_idle)) // RULE1 RULE8 RULE9
                                 |=> $stable(st_reg.flags))
    else $error("flags changed by a flag-neutral instruction");

  idle_pc_a: assert property ((commit && is_idle) // RULE9
      |=> st_reg.pc == $past(st_reg.pc) + 16'h0001)
    else $error("no-op did not step the counter by one byte");

  prod_carry_a: assert property ((commit && is_mul) // RULE6
      |=> st_reg.flags[exec_pkg::FL_C] == ($past(ai.result) > 16'h00ff)
          && !st_reg.flags[exec_pkg::FL_V])
    else $error("product carry or overflow wrong");

  or_flag_a: assert property ((commit && is_or) // RULE11
      |=> st_reg.flags[exec_pkg::FL_C] == $past(st_reg.flags[exec_pkg::FL_C])
          && !st_reg.flags[exec_pkg::FL_V])
    else $error("or disturbed carry or left overflow set");

  prod_hi_a: assert property ((commit && is_mul) // RULE5
      |=> rf_mem[$past(dp0)] == $past(ai.result[15:8]))
    else $error("product upper byte not in even register");

  wmove_lo_a: assert property ((commit && is_wmove) // RULE3
      |=> rf_mem[$past(dp1)] == $past(src_w[7:0]))
    else $error("word move odd byte misplaced");

  commit_end_a: assert property (commit |=> !busy) // RULE13
    else $error("unit still busy after commit");

endmodule : exec_unit

// ==== tb_word_move_multiply_or_exec.sv ====
// self-checking bench for the five-instruction execution unit, driven over avalon-mm
`timescale 1ns/100ps
module tb_word_move_multiply_or_exec;
  logic        CORE_CLK;
  logic        RST;
  logic [11:0] AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [31:0] cyc;
  logic [31:0] taken;
  logic [15:0] pc_exp;
  int          num_errors;
  int          checked;

  exec_unit DUT (
    .CORE_CLK       (CORE_CLK),
    .RST            (RST),
    .AVS_ADDRESS    (AVS_ADDRESS),
    .AVS_READ       (AVS_READ),
    .AVS_WRITE      (AVS_WRITE),
    .AVS_WRITEDATA  (AVS_WRITEDATA),
    .AVS_BYTEENABLE (AVS_BYTEENABLE),
    .AVS_READDATA   (AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST)
  );

  // 40 mhz core clock and a free cycle count used to time the stalls
  always #12.5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) cyc <= cyc + 32'h1;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // a request is held until waitrequest is sampled low, then released one edge
  task wr(input logic [11:0] a, input logic [31:0] d);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= 1'b1;
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    taken = cyc;
    AVS_WRITE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : wr

  task rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
    AVS_ADDRESS <= a;
    AVS_READ    <= 1'b1;
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    chk(AVS_READDATA & mask, exp);
    AVS_READ <= 1'b0;
    @(posedge CORE_CLK);
  endtask : rchk

  task sr(input logic [7:0] n, input logic [7:0] v);
    wr(12'h400 + {2'h0, n, 2'h0}, {24'h0, v});
  endtask : sr

  task rr(input logic [7:0] n, input logic [7:0] exp);
    rchk(12'h400 + {2'h0, n, 2'h0}, {24'h0, exp}, 32'hff);
  endtask : rr

  // start one instruction; a stalled write to an unmapped place measures the busy span
  task exec(input logic [31:0] ins, input logic [31:0] n, input logic [15:0] len,
            input logic [7:0] fpre, input logic [7:0] fexp);
    logic [31:0] t0;
    wr(12'h008, {24'h0, fpre});
    wr(12'h004, ins);
    wr(12'h000, 32'h1);
    t0 = taken;
    wr(12'h100, 32'h0);
    chk(taken - t0, n + 32'h1);
    pc_exp = pc_exp + len;
    rchk(12'h00c, {16'h0, pc_exp}, 32'hffff);
    rchk(12'h008, {24'h0, fexp & 8'hfc}, 32'hfc);
  endtask : exec

  task t_reset;
    rchk(12'h004, 32'hff, 32'hffffffff);
    rchk(12'h008, 32'h0, 32'hff);
    rchk(12'h00c, 32'h0, 32'hffff);
    rchk(12'h010, 32'h0, 32'hffff);
    rchk(12'h100, 32'h0, 32'hffffffff);
  endtask : t_reset

  task t_word_move;
    sr(8'h04, 8'h06);
    sr(8'h05, 8'h1c);
    wr(12'h00c, 32'h0100);
    pc_exp = 16'h0100;
    exec(32'h0006_04c4, 32'h8, 16'h3, 8'hf0, 8'hf0);
    rr(8'h06, 8'h06);
    rr(8'h07, 8'h1c);
    rr(8'h04, 8'h06);
    rr(8'h05, 8'h1c);
    sr(8'h01, 8'h02);
    sr(8'h02, 8'h03);
    sr(8'h03, 8'h0f);
    exec(32'h0004_01c5, 32'h8, 16'h3, 8'h0c, 8'h0c);
    rr(8'h04, 8'h03);
    rr(8'h05, 8'h0f);
    exec(32'h3412_02c6, 32'h8, 16'h4, 8'hf0, 8'hf0);
    rr(8'h02, 8'h12);
    rr(8'h03, 8'h34);
  endtask : t_word_move

  // the odd register holds junk to show only the even one is a factor
  task t_product;
    sr(8'h00, 8'h20);
    sr(8'h01, 8'h03);
    sr(8'h02, 8'h09);
    exec(32'h0000_0284, 32'h16, 16'h3, 8'h1c, 8'h8c);
    rr(8'h00, 8'h01);
    rr(8'h01, 8'h20);
    rr(8'h02, 8'h09);
    sr(8'h20, 8'hff);
    sr(8'h30, 8'h31);
    sr(8'h31, 8'hff);
    exec(32'h0020_3085, 32'h16, 16'h3, 8'h00, 8'ha0);
    rr(8'h20, 8'hfe);
    rr(8'h21, 8'h01);
    sr(8'h10, 8'h55);
    exec(32'h0010_0086, 32'h16, 16'h3, 8'hbc, 8'h4c);
    rr(8'h10, 8'h00);
    rr(8'h11, 8'h00);
  endtask : t_product

  task t_dispatch;
    wr(12'h20c, 32'h0abc);
    wr(12'h010, 32'h0006);
    pc_exp = 16'h0abc;
    exec(32'h0000_000f, 32'ha, 16'h0, 8'hf0, 8'hf0);
    rchk(12'h010, 32'h0008, 32'hffff);
  endtask : t_dispatch

  task t_idle;
    sr(8'h60, 8'ha5);
    exec(32'h0000_00ff, 32'h4, 16'h1, 8'h5c, 8'h5c);
    rr(8'h60, 8'ha5);
    rchk(12'h010, 32'h0008, 32'hffff);
  endtask : t_idle

  // one case per or form, flags preset so held and cleared bits both show
  task t_or;
    sr(8'hc0, 8'h15);
    sr(8'hc1, 8'h2a);
    exec(32'h0000_0142, 32'h4, 16'h2, 8'hcc, 8'h8c);
    rr(8'hc0, 8'h3f);
    rr(8'hc1, 8'h2a);
    sr(8'hc2, 8'h40);
    sr(8'h40, 8'h80);
    sr(8'hc3, 8'h00);
    exec(32'h0000_3243, 32'h6, 16'h2, 8'h10, 8'h20);
    rr(8'hc3, 8'h80);
    sr(8'h50, 8'h00);
    sr(8'h51, 8'h00);
    exec(32'h0051_5044, 32'h6, 16'h3, 8'h00, 8'h40);
    rr(8'h51, 8'h00);
    sr(8'h52, 8'h53);
    sr(8'h53, 8'h0f);
    sr(8'h54, 8'hf0);
    exec(32'h0054_5245, 32'h6, 16'h3, 8'h00, 8'h20);
    rr(8'h54, 8'hff);
    rr(8'h53, 8'h0f);
    sr(8'h55, 8'h08);
    exec(32'h0002_5546, 32'h6, 16'h3, 8'h80, 8'h80);
    rr(8'h55, 8'h0a);
  endtask : t_or

  // a start without byte lane 0 is ignored; an unknown opcode must not move the counter;
  // the next legal start clears the mark
  task t_illegal;
    wr(12'h004, 32'h0);
    AVS_BYTEENABLE <= 4'he;
    wr(12'h000, 32'h1);
    AVS_BYTEENABLE <= 4'hf;
    rchk(12'h000, 32'h0, 32'h2);
    wr(12'h000, 32'h1);
    rchk(12'h000, 32'h2, 32'h2);
    rchk(12'h00c, {16'h0, pc_exp}, 32'hffff);
    exec(32'h0000_00ff, 32'h4, 16'h1, 8'h00, 8'h00);
    rchk(12'h000, 32'h0, 32'h2);
  endtask : t_illegal

  task results;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    results();
  end

  initial begin
    CORE_CLK       = 1'b0;
    RST            = 1'b1;
    AVS_ADDRESS    = 12'h000;
    AVS_READ       = 1'b0;
    AVS_WRITE      = 1'b0;
    AVS_WRITEDATA  = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    cyc            = 32'h0;
    num_errors     = 0;
    checked        = 0;
    pc_exp         = 16'h0;
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    t_reset();
    t_word_move();
    t_product();
    t_dispatch();
    t_idle();
    t_or();
    t_illegal();
    results();
  end
endmodule : tb_word_move_multiply_or_exec
